// *** src/asl_params.svh ***
`ifndef ASL_PARAMS_SVH
`define ASL_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define ASL_OFS_ADC_CTRL   8'h00
`define ASL_OFS_LIST_PORT  8'h04
`define ASL_OFS_XFER_CTRL  8'h08
`define ASL_OFS_XFER_ADDR  8'h0c
`define ASL_OFS_XFER_WCNT  8'h10
`define ASL_OFS_STATUS     8'h14
`define ASL_OFS_DATA       8'h18

// ************************************************************
// field positions and reset values
// ************************************************************
`define ASL_ADC_GO         0
`define ASL_ADC_EXT        3
`define ASL_ADC_IE         6
`define ASL_ADC_DONE       7
`define ASL_XC_BURST       2
`define ASL_XC_LIST        3
`define ASL_ST_DMA_DONE    1
`define ASL_ADC_CTRL_RST   16'h0000
`define ASL_XFER_CTRL_RST  4'h0

// ************************************************************
// pointer commands in the control high byte (octal as printed)
// ************************************************************
`define ASL_CMD_INIT_WR    8'h03
`define ASL_CMD_LIST_RD    8'h04
`define ASL_CMD_LIST_WR    8'h05
`define ASL_CMD_ARM        8'h06
`define ASL_CMD_INIT_RD    8'h0a
`define ASL_CMD_FIN_RD     8'h12
`define ASL_CMD_PTR_RD     8'h1a
`define ASL_CMD_RESTART    8'h23
`define ASL_CMD_START_WR   8'h2b
`define ASL_CMD_FIN_WR     8'h33

// ************************************************************
// transfer paths, bus answers, timing
// ************************************************************
`define ASL_DMA_PIO        2'h0
`define ASL_DMA_HOST       2'h1
`define ASL_DMA_XPORT      2'h2
`define ASL_RESP_OKAY      2'h0
`define ASL_RESP_SLVERR    2'h2
`define ASL_CLK_PERIOD_NS  25
`define ASL_SSH_PERIOD_NS  10000
`define ASL_SSH_DIV        (`ASL_SSH_PERIOD_NS / `ASL_CLK_PERIOD_NS)

`endif

// *** src/asl_pkg.sv ***
package asl_pkg;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed
	{
		logic [1:0] gain;
		logic [5:0] chan;
	} asl_entry_t;

	typedef struct packed
	{
		logic [15:0] addr;
		logic [15:0] data;
	} asl_dma_word_t;

	typedef enum logic [1:0]
	{
		S_IDLE,
		S_PACE,
		S_CONV,
		S_XFER
	} asl_state_t;

endpackage

// *** src/asl_list_ram.sv ***
`timescale 1ns/1ps

module asl_list_ram
	import asl_pkg::*;
#(
	parameter int unsigned PAGES = 4,
	parameter int unsigned DEPTH = 256
)
(
	input  wire logic                         aclk,
	input  wire logic                         wr_en,
	input  wire logic [$clog2(PAGES)-1:0]     page,
	input  wire logic [$clog2(DEPTH)-1:0]     addr,
	input  wire asl_entry_t                   wr_entry,
	output asl_entry_t                        rd_entry
);

	// ************************************************************
	// page-major array, combinational read keeps the mux current
	// ************************************************************
	asl_entry_t mem [PAGES*DEPTH];

	always_ff @(posedge aclk)
	begin
		if (wr_en)
		begin
			mem[{page, addr}] <= wr_entry;
		end
	end

	assign rd_entry = mem[{page, addr}];

endmodule

// *** src/asl_rate_div.sv ***
`timescale 1ns/1ps

module asl_rate_div
	import asl_pkg::*;
#(
	parameter int unsigned DIV = 400
)
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic en,
	output logic      tick
);

	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_q;

	// restart while disabled so pacing begins a full period after start
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !en || cnt_q == LAST)
		begin
			cnt_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign tick = en && (cnt_q == LAST);

endmodule

// *** src/asl_top.sv ***
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "asl_params.svh"

// ************************************************************
// Overview of operation
// - control write with go set and external clear starts a conversion
// - external enable set: conversions start on external trigger edges
// - transfer control bits 3..2 select single, list scan or burst
// - list scan converts up to final pointer, reloads start, awaits trigger
// - burst converts back to back, repeating the list until the host dma count ends
// - sample-hold variant freezes holds at channel 0, scans paced, releases after the final entry
// - transfer control bits 1..0 choose pio, host dma or external port
// - pio gives a pollable done flag and optional interrupt per conversion
// - host dma bumps address and counter per word; zero sets dma done
// - external port dma sends data only on the external port
// - list ram is four pages of 256 entries, page from control
// - command 012: port high byte reads back the init code
// - command 053: high byte write loads start and current pointers
// - in acquisition current equal final presets current to start
// - command 032: port high byte reads the current pointer
// - command 063: high byte write loads the final pointer
// - command 043: any high byte write copies start into current
// - command 005: low byte write stores entry, advances pointer with wrap
// - entry holds channel in bits 5..0 and gain code in bits 7..6
// - command 006: low byte write preloads the mux and arms conversions
// ************************************************************

module asl_top
	import asl_pkg::*;
#(
	parameter bit          SSH_VARIANT = 1'b0,
	parameter int unsigned SSH_DIV     = `ASL_SSH_DIV
)
(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          ext_trig,
	output logic               conv_start,
	output asl_entry_t         conv_sel,
	output logic               hold_freeze,
	input  wire logic          conv_done,
	input  wire logic [15:0]   conv_data,
	output logic               hdma_valid,
	output asl_dma_word_t      hdma_word,
	input  wire logic          hdma_ready,
	output logic               xp_valid,
	output logic [15:0]        xp_data,
	input  wire logic          xp_ready,
	output logic               conv_irq
);

	// ************************************************************
	// axi4-lite write channel
	// ************************************************************
	logic          aw_hold_q;
	logic          w_hold_q;
	logic [7:0]    awaddr_q;
	logic [31:0]   wdata_q;
	logic [3:0]    wstrb_q;
	logic          bvalid_q;
	logic [1:0]    bresp_q;
	logic [7:0]    wa;
	logic          wr_fire;
	logic          wr_hit;

	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign wr_fire       = aw_hold_q && w_hold_q && !bvalid_q;
	assign wa            = {awaddr_q[7:2], 2'b00};
	assign wr_hit        = wa == `ASL_OFS_ADC_CTRL || wa == `ASL_OFS_LIST_PORT
		|| wa == `ASL_OFS_XFER_CTRL || wa == `ASL_OFS_XFER_ADDR
		|| wa == `ASL_OFS_XFER_WCNT || wa == `ASL_OFS_STATUS;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `ASL_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? `ASL_RESP_OKAY : `ASL_RESP_SLVERR;
			end
			else if (s_axi_bready)
			begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// register state and write decode
	// ************************************************************
	logic [15:0]   adc_ctrl_q;
	logic [3:0]    xfer_ctrl_q;
	logic [15:0]   xfer_addr_q;
	logic [15:0]   xfer_wcnt_q;
	logic [7:0]    start_q;
	logic [7:0]    cur_q;
	logic [7:0]    cur_d;
	logic [7:0]    fin_q;
	logic [7:0]    init_q;
	logic [7:0]    cmd;
	logic [7:0]    wr_hi;
	logic          hi_wr;
	logic          lo_wr;
	logic          wr_adc;
	logic          ptr_load_wr;
	logic          restart_wr;
	logic          list_wr;
	logic          arm_wr;
	logic          list_rd;
	logic          acq_step;
	logic [7:0]    cur_next;
	logic          at_final;

	assign cmd         = adc_ctrl_q[15:8];
	assign wr_hi       = wdata_q[15:8];
	assign hi_wr       = wr_fire && wa == `ASL_OFS_LIST_PORT && wstrb_q[1];
	assign lo_wr       = wr_fire && wa == `ASL_OFS_LIST_PORT && wstrb_q[0];
	assign wr_adc      = wr_fire && wa == `ASL_OFS_ADC_CTRL;
	assign ptr_load_wr = hi_wr && cmd == `ASL_CMD_START_WR;
	assign restart_wr  = hi_wr && cmd == `ASL_CMD_RESTART;
	assign list_wr     = lo_wr && cmd == `ASL_CMD_LIST_WR;
	assign arm_wr      = lo_wr && cmd == `ASL_CMD_ARM;
	assign at_final    = cur_q == fin_q;
	assign cur_next    = at_final ? start_q : cur_q + 8'h01;

	// load and restart win over list and acquisition steps; other commands leave all alone
	always_comb
	begin
		cur_d = cur_q;
		if (ptr_load_wr)
		begin
			cur_d = wr_hi;
		end
		else if (restart_wr)
		begin
			cur_d = start_q;
		end
		else if (list_wr || list_rd || acq_step)
		begin
			cur_d = cur_next;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			start_q <= 8'h00;
			cur_q   <= 8'h00;
			fin_q   <= 8'h00;
			init_q  <= 8'h00;
		end
		else
		begin
			cur_q <= cur_d;
			if (ptr_load_wr)
			begin
				start_q <= wr_hi;
			end
			if (hi_wr && cmd == `ASL_CMD_FIN_WR)
			begin
				fin_q <= wr_hi;
			end
			if (hi_wr && cmd == `ASL_CMD_INIT_WR)
			begin
				init_q <= wr_hi;
			end
		end
	end

	// ************************************************************
	// channel list ram, one page addressed by the pointer
	// ************************************************************
	asl_entry_t ram_entry;

	asl_list_ram #(
		.PAGES (4),
		.DEPTH (256)
	) u_ram (
		.aclk     (aclk),
		.wr_en    (list_wr),
		.page     (adc_ctrl_q[2:1]),
		.addr     (cur_q),
		.wr_entry (asl_entry_t'(wdata_q[7:0])),
		.rd_entry (ram_entry)
	);

	// ************************************************************
	// triggers, mode decode, pacing
	// ************************************************************
	asl_state_t    state_q;
	logic          trig_s1_q;
	logic          trig_s2_q;
	logic          trig_s3_q;
	logic          ext_edge;
	logic          sw_trig;
	logic          trigger;
	logic          mode_list;
	logic          mode_burst;
	logic [1:0]    dma_mode;
	logic          use_host;
	logic          use_xp;
	logic          rate_tick;
	logic          pace_ok;

	assign ext_edge   = trig_s2_q && !trig_s3_q;
	assign sw_trig    = wr_adc && wstrb_q[0] && wdata_q[`ASL_ADC_GO]
		&& !wdata_q[`ASL_ADC_EXT];
	assign trigger    = sw_trig || (adc_ctrl_q[`ASL_ADC_EXT] && ext_edge);
	// with the hold variant a trigger in single mode (bits 3..2 clear) also scans the list
	assign mode_list  = (xfer_ctrl_q[`ASL_XC_LIST] && !xfer_ctrl_q[`ASL_XC_BURST])
		|| (SSH_VARIANT && !xfer_ctrl_q[`ASL_XC_LIST] && !xfer_ctrl_q[`ASL_XC_BURST]);
	assign mode_burst = xfer_ctrl_q[`ASL_XC_BURST] && !xfer_ctrl_q[`ASL_XC_LIST];
	assign dma_mode   = xfer_ctrl_q[1:0];
	assign use_host   = dma_mode == `ASL_DMA_HOST;
	assign use_xp     = dma_mode == `ASL_DMA_XPORT;
	assign pace_ok    = !SSH_VARIANT || rate_tick;

	asl_rate_div #(
		.DIV (SSH_DIV)
	) u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.en      (state_q != S_IDLE),
		.tick    (rate_tick)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
		end
		else
		begin
			trig_s1_q <= ext_trig;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
		end
	end

	// ************************************************************
	// conversion sequencer
	// ************************************************************
	logic          armed_q;
	logic          wrap_q;
	logic [15:0]   data_q;
	logic          hold_q;
	logic          start_q_pulse;
	asl_entry_t    chan_q;
	logic          xfer_ok;
	logic          last_word;
	logic          host_word;

	assign acq_step  = state_q == S_CONV && conv_done;
	assign host_word = state_q == S_XFER && use_host && hdma_ready;
	assign last_word = xfer_wcnt_q == 16'hffff;
	assign xfer_ok   = state_q == S_XFER && (use_host ? hdma_ready
		: (use_xp ? xp_ready : 1'b1));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= S_IDLE;
		end
		else
		begin
			case (state_q)
				S_IDLE:
				begin
					if (trigger && armed_q)
					begin
						state_q <= S_PACE;
					end
				end
				S_PACE:
				begin
					if (pace_ok)
					begin
						state_q <= S_CONV;
					end
				end
				S_CONV:
				begin
					if (conv_done)
					begin
						state_q <= S_XFER;
					end
				end
				S_XFER:
				begin
					if (xfer_ok)
					begin
						if ((use_host && last_word) || (!mode_list && !mode_burst)
							|| (mode_list && wrap_q))
						begin
							state_q <= S_IDLE;
						end
						else
						begin
							state_q <= S_PACE;
						end
					end
				end
				default:
				begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// mux follows the list while armed; only an arm write moves it mid-conversion
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			armed_q       <= 1'b0;
			chan_q        <= '0;
			wrap_q        <= 1'b0;
			data_q        <= 16'h0000;
			hold_q        <= 1'b0;
			start_q_pulse <= 1'b0;
		end
		else
		begin
			start_q_pulse <= state_q == S_PACE && pace_ok;
			if (arm_wr)
			begin
				armed_q <= 1'b1;
			end
			else if (host_word && last_word)
			begin
				armed_q <= 1'b0;
			end
			if (arm_wr || (armed_q && state_q != S_CONV))
			begin
				chan_q <= ram_entry;
			end
			if (acq_step)
			begin
				wrap_q <= at_final;
				data_q <= conv_data;
			end
			if (SSH_VARIANT && state_q == S_PACE && pace_ok && chan_q.chan == 6'h00)
			begin
				hold_q <= 1'b1;
			end
			else if (xfer_ok && wrap_q)
			begin
				hold_q <= 1'b0;
			end
		end
	end

	assign conv_start  = start_q_pulse;
	assign conv_sel    = chan_q;
	assign hold_freeze = hold_q;
	assign hdma_valid  = state_q == S_XFER && use_host;
	assign hdma_word   = {xfer_addr_q, data_q};
	assign xp_valid    = state_q == S_XFER && use_xp;
	assign xp_data     = data_q;

	// ************************************************************
	// transfer registers and flags
	// ************************************************************
	logic          conv_flag_q;
	logic          dma_done_q;
	logic          irq_q;
	logic          rd_fire;
	logic [7:0]    ra;
	logic          data_rd;
	logic          dma_clr;

	assign dma_clr = wr_fire && wa == `ASL_OFS_STATUS && wstrb_q[0]
		&& wdata_q[`ASL_ST_DMA_DONE];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			adc_ctrl_q  <= `ASL_ADC_CTRL_RST;
			xfer_ctrl_q <= `ASL_XFER_CTRL_RST;
			xfer_addr_q <= 16'h0000;
			xfer_wcnt_q <= 16'h0000;
			conv_flag_q <= 1'b0;
			dma_done_q  <= 1'b0;
			irq_q       <= 1'b0;
		end
		else
		begin
			if (wr_adc && wstrb_q[0])
			begin
				adc_ctrl_q[7:0] <= wdata_q[7:0];
			end
			if (wr_adc && wstrb_q[1])
			begin
				adc_ctrl_q[15:8] <= wr_hi;
			end
			if (wr_fire && wa == `ASL_OFS_XFER_CTRL && wstrb_q[0])
			begin
				xfer_ctrl_q <= wdata_q[3:0];
			end
			if (wr_fire && wa == `ASL_OFS_XFER_ADDR)
			begin
				xfer_addr_q <= wdata_q[15:0];
			end
			else if (host_word)
			begin
				xfer_addr_q <= xfer_addr_q + 16'h0001;
			end
			if (wr_fire && wa == `ASL_OFS_XFER_WCNT)
			begin
				xfer_wcnt_q <= wdata_q[15:0];
			end
			else if (host_word)
			begin
				xfer_wcnt_q <= xfer_wcnt_q + 16'h0001;
			end
			// set wins over the clear in both flags
			if (xfer_ok && dma_mode == `ASL_DMA_PIO)
			begin
				conv_flag_q <= 1'b1;
			end
			else if (data_rd)
			begin
				conv_flag_q <= 1'b0;
			end
			if (host_word && last_word)
			begin
				dma_done_q <= 1'b1;
			end
			else if (dma_clr)
			begin
				dma_done_q <= 1'b0;
			end
			irq_q <= (conv_flag_q || dma_done_q) && adc_ctrl_q[`ASL_ADC_IE];
		end
	end

	assign conv_irq = irq_q;

	// ************************************************************
	// axi4-lite read channel
	// ************************************************************
	logic          rvalid_q;
	logic [31:0]   rdata_q;
	logic [1:0]    rresp_q;
	logic [31:0]   rd_mux;
	logic [15:0]   port_rd;
	logic          rd_hit;

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rd_fire       = s_axi_arvalid && !rvalid_q;
	assign ra            = {s_axi_araddr[7:2], 2'b00};
	assign data_rd       = rd_fire && ra == `ASL_OFS_DATA;
	assign list_rd       = rd_fire && ra == `ASL_OFS_LIST_PORT && cmd == `ASL_CMD_LIST_RD;
	assign rd_hit        = wr_hit_r(ra);
	assign port_rd       = cmd == `ASL_CMD_INIT_RD ? {init_q, 8'h00}
		: cmd == `ASL_CMD_PTR_RD ? {cur_q, 8'h00}
		: cmd == `ASL_CMD_FIN_RD ? {fin_q, 8'h00}
		: cmd == `ASL_CMD_LIST_RD ? {cur_q, ram_entry} : 16'h0000;

	function automatic logic wr_hit_r(input logic [7:0] a);
		wr_hit_r = a == `ASL_OFS_ADC_CTRL || a == `ASL_OFS_LIST_PORT
			|| a == `ASL_OFS_XFER_CTRL || a == `ASL_OFS_XFER_ADDR
			|| a == `ASL_OFS_XFER_WCNT || a == `ASL_OFS_STATUS || a == `ASL_OFS_DATA;
	endfunction

	always_comb
	begin
		case (ra)
			`ASL_OFS_ADC_CTRL:  rd_mux = {16'h0000, cmd, conv_flag_q, adc_ctrl_q[6:0]};
			`ASL_OFS_LIST_PORT: rd_mux = {16'h0000, port_rd};
			`ASL_OFS_XFER_CTRL: rd_mux = {28'h0000000, xfer_ctrl_q};
			`ASL_OFS_XFER_ADDR: rd_mux = {16'h0000, xfer_addr_q};
			`ASL_OFS_XFER_WCNT: rd_mux = {16'h0000, xfer_wcnt_q};
			`ASL_OFS_STATUS:    rd_mux = {16'h0000, cur_q, 3'h0, hold_q,
				state_q != S_IDLE, armed_q, dma_done_q, conv_flag_q};
			`ASL_OFS_DATA:      rd_mux = {16'h0000, data_q};
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `ASL_RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= rd_hit ? `ASL_RESP_OKAY : `ASL_RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			rvalid_q <= 1'b0;
		end
	end

endmodule

// *** verif/asl_top_chk.sv ***
`timescale 1ns/1ps

module asl_top_chk
	import asl_pkg::*;
(
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		s_axi_awvalid,
	input wire logic		s_axi_awready,
	input wire logic		s_axi_wvalid,
	input wire logic		s_axi_wready,
	input wire logic		s_axi_bvalid,
	input wire logic [7:0]	s_axi_araddr,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic		s_axi_rvalid,
	input wire logic		conv_start,
	input wire logic		hdma_valid,
	input wire asl_dma_word_t	hdma_word,
	input wire logic		hdma_ready,
	input wire logic		xp_valid
);
	// ***
	// bus and transfer properties
	// ***
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	property p_wr_lat;
		s_wr_taken |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write answer late");
	property p_rd_lat;
		s_rd_taken |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer late");
	property p_unmap;
		s_rd_taken ##0 (s_axi_araddr[7:2] > 6'h06) |=> s_axi_rresp == 2'h2 && s_axi_rdata == '0;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not refused");
	property p_wbusy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wbusy: assert property (p_wbusy)
		else $error("write taken during answer");
	property p_rbusy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rbusy: assert property (p_rbusy)
		else $error("read taken during answer");
	// no new start within six cycles of the previous one
	property p_gap;
		conv_start |=> !conv_start [*6];
	endproperty
	a_gap: assert property (p_gap)
		else $error("start during conversion");
	property p_hold;
		hdma_valid && !hdma_ready |=> hdma_valid && $stable(hdma_word);
	endproperty
	a_hold: assert property (p_hold)
		else $error("dma word dropped");
	property p_excl;
		!(hdma_valid && xp_valid);
	endproperty
	a_excl: assert property (p_excl)
		else $error("two transfer paths at once");
endmodule

bind asl_top asl_top_chk i_asl_top_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .conv_start,
	.hdma_valid, .hdma_word, .hdma_ready, .xp_valid);

// *** verif/asl_conv_model.sv ***
`timescale 1ns/1ps

module asl_conv_model
	import asl_pkg::*;
(
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		conv_start,
	input wire asl_entry_t	conv_sel,
	output logic			conv_done,
	output logic [15:0]	conv_data,
	output logic			hdma_ready,
	output logic			xp_ready
);
	// ***
	// converter and sinks
	// ***
	logic [2:0]	cnt_q;
	logic [2:0]	slow_q;
	asl_entry_t	sel_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_q <= 3'h0;
			slow_q <= 3'h0;
			sel_q <= 8'h00;
			conv_done <= 1'h0;
			conv_data <= 16'h0000;
		end
		else
		begin
			slow_q <= slow_q + 3'h1;
			sel_q <= conv_start ? conv_sel : sel_q;
			cnt_q <= conv_start ? 3'h6 : cnt_q - {2'h0, cnt_q != 3'h0};
			conv_done <= cnt_q == 3'h1;
			// data lines not held between results: show the inverse
			conv_data <= (cnt_q == 3'h1) ? {8'h5a, sel_q} : ~conv_data;
		end
	end
	// sinks stall half the time so held words get exercised
	assign hdma_ready = slow_q[1];
	assign xp_ready = slow_q[2];
endmodule

// *** verif/asl_top_tb.sv ***
`timescale 1ns/1ps

module asl_top_tb
	import asl_pkg::*;
;
	// ***
	// bench
	// ***
	logic			aclk = 0, aresetn = 0, ext_trig = 0;
	logic			s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic			s_axi_bready = 1, s_axi_rready = 1;
	logic [7:0]		s_axi_awaddr = 0, s_axi_araddr = 0, s;
	logic [31:0]	s_axi_wdata = 0, s_axi_rdata, d, xd;
	logic [3:0]		s_axi_wstrb = 0;
	logic [1:0]		s_axi_bresp, s_axi_rresp, r;
	logic			s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic			conv_start, hold_freeze, conv_done, hdma_valid, hdma_ready;
	logic			xp_valid, xp_ready, conv_irq;
	logic [15:0]	conv_data, xp_data;
	asl_entry_t		conv_sel;
	asl_dma_word_t	hdma_word, hw;
	int				err_count = 0, n_checks = 0, n_start = 0, n_hw = 0, n_xp = 0;

	always #12.5 aclk = ~aclk;

	// hold variant left off, so list order is unrestricted
	asl_top #(.SSH_DIV(4)) i_asl_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ext_trig, .conv_start, .conv_sel, .hold_freeze, .conv_done, .conv_data,
		.hdma_valid, .hdma_word, .hdma_ready, .xp_valid, .xp_data, .xp_ready, .conv_irq);
	asl_conv_model i_asl_conv_model (.aclk, .aresetn, .conv_start, .conv_sel,
		.conv_done, .conv_data, .hdma_ready, .xp_ready);

	always @(posedge aclk)
	begin
		if (conv_start)
		begin
			s <= conv_sel;
			n_start <= n_start + 1;
		end
		if (hdma_valid && hdma_ready)
		begin
			hw <= hdma_word;
			n_hw <= n_hw + 1;
		end
		if (xp_valid && xp_ready)
		begin
			xd <= {16'h0, xp_data};
			n_xp <= n_xp + 1;
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] b,
		input logic [1:0] er);
		bit aw, w;
		int n;
		aw = 1;
		w = 1;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= b;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do
		begin
			@(posedge aclk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		while ((aw || w) && n++ < 100);
		do @(posedge aclk); while (!s_axi_bvalid && n++ < 200);
		chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
	endtask

	task automatic axr(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready && n++ < 100);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid && n++ < 200);
		d = s_axi_rdata;
		r = s_axi_rresp;
		chk({31'h0, s_axi_rvalid}, 32'h1);
	endtask

	task automatic cmd(input logic [7:0] c);
		axw(8'h00, {16'h0, c, 8'h00}, 4'h2, 2'h0);
	endtask

	task automatic pw(input logic [7:0] hi, input logic [7:0] lo, input logic [3:0] b);
		axw(8'h04, {16'h0, hi, lo}, b, 2'h0);
	endtask

	task automatic rdp(input logic [7:0] c, input logic [7:0] e);
		cmd(c);
		axr(8'h04);
		chk({24'h0, d[15:8]}, {24'h0, e});
	endtask

	task automatic wt(ref int c, input int k);
		int n;
		n = 0;
		do @(posedge aclk); while (c < k && n++ < 300);
		chk({31'h0, c >= k}, 32'h1);
	endtask

	task automatic wflag();
		int n;
		n = 0;
		do axr(8'h14); while (d[0] !== 1'h1 && n++ < 30);
		chk({31'h0, d[0]}, 32'h1);
	endtask

	task automatic t_ptrs();
		cmd(8'h03);
		pw(8'h02, 8'h00, 4'h2);
		rdp(8'h0a, 8'h02);
		cmd(8'h2b);
		pw(8'h05, 8'h00, 4'h2);
		rdp(8'h1a, 8'h05);
		cmd(8'h33);
		pw(8'h07, 8'h00, 4'h2);
		rdp(8'h12, 8'h07);
		$display("pointer test done");
	endtask

	task automatic t_list();
		cmd(8'h05);
		pw(8'h00, 8'h85, 4'h1);
		pw(8'h00, 8'hc6, 4'h1);
		pw(8'h00, 8'h07, 4'h1);
		rdp(8'h1a, 8'h05);
		cmd(8'h04);
		axr(8'h04);
		chk(d, 32'h0585);
		cmd(8'h23);
		pw(8'hee, 8'h00, 4'h2);
		rdp(8'h1a, 8'h05);
		cmd(8'h7f);
		pw(8'h33, 8'h44, 4'h3);
		rdp(8'h1a, 8'h05);
		rdp(8'h12, 8'h07);
		$display("list test done");
	endtask

	task automatic t_conv();
		cmd(8'h06);
		pw(8'h00, 8'h00, 4'h1);
		cmd(8'h00);
		axw(8'h00, 32'h1, 4'h1, 2'h0);
		wt(n_start, 1);
		chk({24'h0, s}, 32'h85);
		wflag();
		axr(8'h18);
		chk(d, 32'h5a85);
		axw(8'h00, 32'h8, 4'h1, 2'h0);
		ext_trig <= 1;
		repeat (2) @(posedge aclk);
		ext_trig <= 0;
		wt(n_start, 2);
		chk({24'h0, s}, 32'hc6);
		wflag();
		axr(8'h18);
		chk(d, 32'h5ac6);
		$display("conversion test done");
	endtask

	task automatic t_dma();
		// single conversion only, so host dma is a legal pairing
		axw(8'h08, 32'h1, 4'h1, 2'h0);
		axw(8'h0c, 32'h100, 4'h3, 2'h0);
		axw(8'h10, 32'hffff, 4'h3, 2'h0);
		axw(8'h00, 32'h1, 4'h1, 2'h0);
		wt(n_hw, 1);
		chk(hw, 32'h01005a07);
		rdp(8'h1a, 8'h05);
		axr(8'h14);
		chk({31'h0, d[1]}, 32'h1);
		axr(8'h0c);
		chk(d, 32'h101);
		axr(8'h10);
		chk(d, 32'h0);
		axw(8'h18, 32'h0, 4'hf, 2'h2);
		axr(8'h1c);
		chk({30'h0, r}, 32'h2);
		$display("dma and bus test done");
	endtask

	task automatic t_xp();
		cmd(8'h06);
		pw(8'h00, 8'h00, 4'h1);
		cmd(8'h00);
		axw(8'h08, 32'ha, 4'h1, 2'h0);
		axw(8'h00, 32'h1, 4'h1, 2'h0);
		wt(n_xp, 3);
		chk(xd, 32'h5a07);
		chk(n_start, 32'h6);
		chk(n_hw, 32'h1);
		axr(8'h14);
		chk(d, 32'h0506);
		axw(8'h00, 32'h40, 4'h1, 2'h0);
		axr(8'h14);
		chk({31'h0, conv_irq}, 32'h1);
		$display("external port test done");
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_ptrs();
		t_list();
		t_conv();
		t_dma();
		t_xp();
		give_verdict();
	end

	initial
	begin
		#1000000;
		err_count++;
		give_verdict();
	end
endmodule
